// File: logic/rate_consts.vh
// constants for the serial port rate generator and its status register
// assumes a 32-bit AHB-Lite register bus and a 100 MHz oscillator clock
`ifndef RATE_CONSTS_VH
`define RATE_CONSTS_VH

// register byte offsets
`define OFF_RELOAD 8'h00
`define OFF_BUFFER 8'h04
`define OFF_STATUS 8'h08
`define OFF_CONTROL 8'h0C

// reset values
`define RELOAD_RESET 8'h00
`define STATUS_RESET 8'h00
`define CONTROL_RESET 8'h00

// status register fields
`define ST_SAMPLE 7
`define ST_EDGE 6
`define ST_DATA_ADDR 5
`define ST_STOP_SEEN 4
`define ST_START_SEEN 3
`define ST_DIRECTION 2
`define ST_UPDATE_ADDR 1
`define ST_BUF_FULL 0

// control register fields
`define CT_PORT_ENABLE 0
`define CT_I2C_MODE 1
`define CT_MASTER 2
`define CT_START_SEQ 3
`define CT_RESTART_SEQ 4
`define CT_STOP_SEQ 5
`define CT_RECEIVE_SEQ 6
`define CT_ACK_SEQ 7

// oscillator cycles per counter decrement, so that one rollover
// lasts (reload + 1) * 2 oscillator cycles
`define PRESCALE 2'h2
// counter rollovers in one byte: two per serial clock period
`define ROLLOVERS_PER_BYTE 5'h10
`endif

// File: logic/sync_stage.v
// two flip-flop synchroniser for one pin input
// assumes the input is asynchronous to hclk
`timescale 1ns/1ps
module sync_stage (
   input wire hclk,
   input wire hresetn,
   input wire d,
   output reg q
);
   reg meta_reg;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // sync_stage

// File: logic/rate_counter.v
// reloadable down-counter of the serial clock generator
// assumes run, hold and reload_value come from logic on hclk
`timescale 1ns/1ps
`include "rate_consts.vh"
module rate_counter (
   input wire hclk,
   input wire hresetn,
   input wire run,
   input wire hold,
   input wire [7:0] reload_value,
   output reg rollover
);
   reg [7:0] count_reg;
   reg [1:0] pre_reg;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= 8'h00;
         pre_reg <= 2'h0;
         rollover <= 1'b0;
      end else begin
         rollover <= 1'b0;
         if (!run || hold) begin
            count_reg <= reload_value;
            pre_reg <= 2'h0;
         end else if (pre_reg == `PRESCALE - 2'h1) begin
            pre_reg <= 2'h0;
            if (count_reg == 8'h00) begin
               count_reg <= reload_value;
               rollover <= 1'b1;
            end else begin
               count_reg <= count_reg - 8'h01;
            end
         end else begin
            pre_reg <= pre_reg + 2'h1;
         end
      end
   end
endmodule // rate_counter

// File: logic/serial_port_rate_gen.v
// serial port rate generator with the port status register
// assumes an AHB-Lite master on hclk; pins arrive asynchronously
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "rate_consts.vh"
module serial_port_rate_gen (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg sck_out,
   output reg sdo_out,
   input wire sdi_in
);
   ////////////////////////////////////////////////////////////////////////
   reg [7:0] reload_reg;
   reg [7:0] control_reg;
   reg [1:0] status_cfg_reg;
   reg start_seen_reg;
   reg stop_seen_reg;
   reg buf_full_reg;
   reg [7:0] shift_reg;
   reg busy_reg;
   reg clk_level_reg;
   reg [4:0] roll_cnt_reg;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;
   reg rd_buf_reg;
   reg scl_prev_reg;
   reg sda_prev_reg;
   reg [2:0] lvl_pipe_reg;
   reg scl_own_reg;
   wire scl_s;
   wire sda_s;
   wire sdi_s;
   wire rollover;
   wire port_en;
   wire i2c_mode;
   wire master;
   wire addr_phase;
   wire buf_write;
   wire buf_read;
   wire hold;
   wire rx_bit;
   wire last_roll;
   wire start_cond;
   wire stop_cond;
   wire [7:0] status_value;
   reg [31:0] read_mux;

   assign port_en = control_reg[`CT_PORT_ENABLE];
   assign i2c_mode = control_reg[`CT_I2C_MODE];
   assign master = control_reg[`CT_MASTER];

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   sync_stage scl_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(scl_in),
      .q(scl_s)
   );
   sync_stage sda_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(sda_in),
      .q(sda_s)
   );
   sync_stage sdi_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(sdi_in),
      .q(sdi_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, always okay
   assign addr_phase = hsel && htrans[1] && hready;
   assign buf_write = wr_pend_reg && (wr_addr_reg == `OFF_BUFFER);
   assign buf_read = addr_phase && !hwrite && (haddr == `OFF_BUFFER);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         if (addr_phase)
            wr_addr_reg <= haddr;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign status_value = {status_cfg_reg, 1'b0, stop_seen_reg, start_seen_reg,
                          i2c_mode && master && busy_reg, 1'b0, buf_full_reg};

   always @* begin
      read_mux = 32'h00000000;
      case (haddr)
         `OFF_RELOAD: read_mux = {24'h000000, reload_reg};
         `OFF_BUFFER: read_mux = {24'h000000, shift_reg};
         `OFF_STATUS: read_mux = {24'h000000, status_value};
         `OFF_CONTROL: read_mux = {24'h000000, control_reg};
         default: read_mux = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         rd_buf_reg <= 1'b0;
      end else begin
         rd_buf_reg <= buf_read;
         if (addr_phase && !hwrite)
            hrdata <= read_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reload_reg <= `RELOAD_RESET;
         control_reg <= `CONTROL_RESET;
         status_cfg_reg <= 2'h0;
      end else if (wr_pend_reg) begin
         // i2c reload values 0x00 to 0x02 are left to software to avoid
         case (wr_addr_reg)
            `OFF_RELOAD: reload_reg <= hwdata[7:0];
            `OFF_STATUS: status_cfg_reg <= hwdata[`ST_SAMPLE:`ST_EDGE];
            `OFF_CONTROL: control_reg <= hwdata[7:0];
            default: control_reg <= control_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rate counter
   // i2c keeps the count reloaded while a slave keeps the released line low; the
   // line reaches scl_s three edges after the level rises, so the hold
   // waits out that lag and an unstretched period stays exact
   assign hold = i2c_mode && lvl_pipe_reg[2] && clk_level_reg && !scl_s;

   // level history for the stretch window, and scl ownership that outlives
   // the byte so the clock line keeps its last low level
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl_pipe_reg <= 3'h0;
         scl_own_reg <= 1'b0;
      end else begin
         lvl_pipe_reg <= {lvl_pipe_reg[1:0], clk_level_reg};
         if (!port_en || !i2c_mode || !master)
            scl_own_reg <= 1'b0;
         else if (busy_reg)
            scl_own_reg <= 1'b1;
      end
   end

   rate_counter counter (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(busy_reg),
      .hold(hold),
      .reload_value(reload_reg),
      .rollover(rollover)
   );

   ////////////////////////////////////////////////////////////////////////
   // serial clock and shift sequencing
   assign rx_bit = i2c_mode ? sda_s : sdi_s;
   assign last_roll = roll_cnt_reg == `ROLLOVERS_PER_BYTE - 5'h01;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg <= 1'b0;
         clk_level_reg <= 1'b0;
         roll_cnt_reg <= 5'h00;
         shift_reg <= 8'h00;
         buf_full_reg <= 1'b0;
      end else begin
         if (!port_en) begin
            busy_reg <= 1'b0;
            clk_level_reg <= 1'b0;
         end else if (buf_write && !busy_reg && master) begin
            busy_reg <= 1'b1;
            roll_cnt_reg <= 5'h00;
            shift_reg <= hwdata[7:0];
         end else if (busy_reg && rollover) begin
            clk_level_reg <= !clk_level_reg;
            roll_cnt_reg <= roll_cnt_reg + 5'h01;
            if (!clk_level_reg)
               shift_reg <= {shift_reg[6:0], rx_bit};
            if (last_roll)
               busy_reg <= 1'b0;
         end
         if (buf_write && !busy_reg && master && port_en)
            buf_full_reg <= 1'b1;
         else if (busy_reg && rollover && last_roll)
            buf_full_reg <= !i2c_mode;
         else if (rd_buf_reg)
            buf_full_reg <= 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_out <= 1'b0;
         sdo_out <= 1'b0;
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         // the clock keeps its level once the counter stops
         sck_out <= clk_level_reg && !i2c_mode;
         // scl stays driven low after the last falling edge of a byte
         scl_oe <= port_en && i2c_mode && master && !clk_level_reg && (busy_reg || scl_own_reg);
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         // data moves only in the low half, so it is steady at each rising edge
         if (!clk_level_reg) begin
            sdo_out <= shift_reg[7];
            sda_oe <= port_en && i2c_mode && busy_reg && !shift_reg[7];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start and stop detection
   assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
   assign stop_cond = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_prev_reg <= 1'b0;
         sda_prev_reg <= 1'b0;
         start_seen_reg <= 1'b0;
         stop_seen_reg <= 1'b0;
      end else begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
         if (!port_en || !i2c_mode) begin
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
         end else if (start_cond) begin
            start_seen_reg <= 1'b1;
            stop_seen_reg <= 1'b0;
         end else if (stop_cond) begin
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b1;
         end
      end
   end
endmodule // serial_port_rate_gen

// File: test/rate_gen_monitor.sv
// checker on the rate generator top ports
// assumes binding onto serial_port_rate_gen
`timescale 1ns/1ps
module rate_gen_monitor (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_out,
   input wire sck_out
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_hi;
      sck_out [*2];
   endsequence
   sequence s_lo;
      !sck_out [*2];
   endsequence
   property p_ok; hreadyout && !hresp; endproperty
   a_ok: assert property (p_ok) else $error("bus answer");
   property p_up; hrdata[31:8] == 24'h000000; endproperty
   a_up: assert property (p_up) else $error("upper read bits");
   property p_pin; !scl_out && !sda_out; endproperty
   a_pin: assert property (p_pin) else $error("pin level");
   property p_mode; !(scl_oe && sck_out); endproperty
   a_mode: assert property (p_mode) else $error("both clocks");
   property p_shi; $rose(sck_out) |-> s_hi; endproperty
   a_shi: assert property (p_shi) else $error("short high");
   property p_slo; $fell(sck_out) |-> s_lo; endproperty
   a_slo: assert property (p_slo) else $error("short low");
   property p_scl; $rose(scl_oe) |-> scl_oe [*8]; endproperty
   a_scl: assert property (p_scl) else $error("short scl low");
   property p_rd; !(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata); endproperty
   a_rd: assert property (p_rd) else $error("read data moved");
endmodule // rate_gen_monitor

// File: test/serial_slave_model.sv
// far side: pulled-up i2c lines and an spi slave
// assumes enables high while driving low
`timescale 1ns/1ps
module serial_slave_model (
   input wire scl_oe,
   input wire scl_hold,
   input wire sda_oe,
   input wire sda_pull,
   input wire sck_out,
   output wire scl_in,
   output wire sda_in,
   output wire sdi_in
);
   logic [7:0] tx = 8'h3C;
   logic armed = 1'h0;
   assign scl_in = !(scl_oe || scl_hold);
   assign sda_in = !(sda_oe || sda_pull);
   assign sdi_in = tx[7];
   // the reset step of sck_out is no clock edge: shift only after a real rise
   always @(posedge sck_out) begin
      armed <= 1'h1;
   end
   always @(negedge sck_out) begin
      if (armed) tx <= {tx[6:0], !tx[0]};
   end
endmodule // serial_slave_model

// File: test/tb.sv
// self-checking bench for the rate generator
// assumes the slave model on the pins
`timescale 1ns/1ps
`include "rate_consts.vh"
module tb;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic mode = 1'h0;
   logic sda_pull = 1'h0;
   logic scl_hold = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [7:0] haddr = 8'h00;
   logic [7:0] rx;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] v;
   int bad_count = 0;
   int check_count = 0;
   int n;
   wire [31:0] hrdata;
   wire hreadyout, hresp, scl_in, scl_oe, sda_in, sda_oe, sck_out, sdo_out, sdi_in;
   wire ln = mode ? scl_in : sck_out;
   always #5 hclk = !hclk;
   serial_port_rate_gen i_serial_port_rate_gen (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_in),
      .sda_out(), .sda_oe(sda_oe), .sck_out(sck_out), .sdo_out(sdo_out), .sdi_in(sdi_in));
   serial_slave_model i_serial_slave_model (.scl_oe(scl_oe), .scl_hold(scl_hold), .sda_oe(sda_oe), .sda_pull(sda_pull),
      .sck_out(sck_out), .scl_in(scl_in), .sda_in(sda_in), .sdi_in(sdi_in));
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic hang();
      bad_count++;
      final_report();
   endtask
   task automatic rdy();
      for (n = 0; n < 99; n++) begin
         @(posedge hclk);
         if (hreadyout === 1'h1) break;
      end
      if (n == 99) hang();
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      v = hrdata;
   endtask
   task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'h0, 32'h0);
      chk(s, e, v);
   endtask
   task automatic rise();
      logic p;
      p = ln;
      for (n = 0; n < 999; n++) begin
         @(posedge hclk);
         if (ln && !p) break;
         p = ln;
      end
      if (n == 999) hang();
   endtask
   task automatic t_regs();
      rc("status", `OFF_STATUS, 32'h00);
      bus(`OFF_RELOAD, 1'h1, 32'h27);
      rc("reload", `OFF_RELOAD, 32'h27);
      rc("unmapped", 8'h10, 32'h00);
      $display("register test done");
   endtask
   task automatic t_flags();
      bus(`OFF_CONTROL, 1'h1, 32'h03);
      sda_pull <= 1'h1;
      repeat (9) @(posedge hclk);
      rc("start", `OFF_STATUS, 32'h08);
      sda_pull <= 1'h0;
      repeat (9) @(posedge hclk);
      rc("stop", `OFF_STATUS, 32'h10);
      bus(`OFF_CONTROL, 1'h1, 32'h00);
      @(posedge hclk);
      rc("flags off", `OFF_STATUS, 32'h00);
      $display("flag test done");
   endtask
   task automatic t_spi();
      bus(`OFF_RELOAD, 1'h1, 32'h03);
      bus(`OFF_CONTROL, 1'h1, 32'h05);
      bus(`OFF_BUFFER, 1'h1, 32'hA5);
      bus(`OFF_BUFFER, 1'h1, 32'hFF);
      for (int i = 0; i < 8; i++) begin
         rise();
         if (i > 0) chk("sck period", 32'h0F, n);
         rx = {rx[6:0], sdo_out};
      end
      chk("sdo byte", 32'hA5, {24'h0, rx});
      repeat (40) @(posedge hclk);
      n = 0;
      repeat (40) begin
         @(posedge hclk);
         if (sck_out !== 1'h0) n++;
      end
      chk("sck idle", 32'h0, n);
      rc("spi status", `OFF_STATUS, 32'h01);
      rc("spi rx", `OFF_BUFFER, 32'h3C);
      $display("spi test done");
   endtask
   task automatic t_i2c();
      mode <= 1'h1;
      bus(`OFF_CONTROL, 1'h1, 32'h07);
      bus(`OFF_BUFFER, 1'h1, 32'h5A);
      rc("busy", `OFF_STATUS, 32'h05);
      rise();
      rise();
      chk("scl period", 32'h0F, n);
      scl_hold <= 1'h1;
      v = 32'h0;
      repeat (20) begin
         @(posedge hclk);
         if (scl_oe !== 1'h0) v++;
      end
      chk("stretch", 32'h0, v);
      scl_hold <= 1'h0;
      rise();
      rise();
      rise();
      chk("scl after stretch", 32'h0F, n);
      repeat (300) @(posedge hclk);
      rc("idle", `OFF_STATUS, 32'h00);
      chk("scl rest", 32'h0, scl_in);
      $display("i2c test done");
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      t_regs();
      t_flags();
      t_spi();
      t_i2c();
      final_report();
   end
endmodule // tb
bind serial_port_rate_gen rate_gen_monitor i_rate_gen_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sck_out(sck_out));
